// ==== rtl/ccr_charger_config_regs.sv ====
// three charger configuration registers with watchdog and clamping
// assumes the serial engine drives the register port on ref_clk

module ccr_charger_config_regs
  import ccr_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              clkEn,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  output logic      [7:0]        regRdData,
  input  wire logic              regResetCmd,
  input  wire logic              wdRestart,
  output logic                   wdRestartDone,
  output logic                   wdExpired,
  output ccr_pkg::ccr_cfg_s      cfg
);
  import ccr_pkg::*;

  logic [7:0]  rVoltage;
  logic [7:0]  rTerm;
  logic [7:0]  rComp;
  logic [31:0] tickCnt;
  logic [7:0]  secCnt;
  logic        expireNow;
  logic        restoreNow;
  logic        wrVoltage;
  logic        wrTerm;
  logic        wrComp;
  logic        wrOk;

  function automatic logic [5:0] clampCode(input logic [5:0] code);
    clampCode = (code > CVC_MAX_CODE) ? CVC_MAX_CODE : code;
  endfunction : clampCode

  function automatic logic [7:0] wdLimit(input logic [1:0] sel);
    if (sel == WD_SEL_40) begin
      wdLimit = WD_40_S;
    end else if (sel == WD_SEL_80) begin
      wdLimit = WD_80_S;
    end else begin
      wdLimit = WD_160_S;
    end
  endfunction : wdLimit

  always_comb begin
    wrVoltage = 1'b0;
    wrTerm    = 1'b0;
    wrComp    = 1'b0;
    if (regWrEn && regAddr == ADDR_VOLTAGE) begin
      wrVoltage = 1'b1;
    end else if (regWrEn && regAddr == ADDR_TERM) begin
      wrTerm = 1'b1;
    end else if (regWrEn && regAddr == ADDR_COMP) begin
      wrComp = 1'b1;
    end
  end

  assign expireNow  = (rTerm[WD_MSB:WD_LSB] != WD_SEL_OFF) &&
                      (secCnt == wdLimit(rTerm[WD_MSB:WD_LSB]));
  assign restoreNow = regResetCmd || expireNow;
  // a write lands only when enabled and not overruled by a restore
  assign wrOk       = clkEn && !restoreNow;

  // reset and expiry beat a same-cycle write
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rVoltage <= RST_VOLTAGE;
    end else if (clkEn) begin
      if (restoreNow) begin
        rVoltage <= RST_VOLTAGE;
      end else if (wrVoltage) begin
        rVoltage <= {clampCode(regWrData[CVC_MSB:CVC_LSB]),
                     regWrData[PRECHG_BIT], regWrData[RECHG_BIT]};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rTerm <= RST_TERM;
    end else if (clkEn) begin
      if (restoreNow) begin
        rTerm <= RST_TERM;
      end else if (wrTerm) begin
        rTerm <= regWrData;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rComp <= RST_COMP;
    end else if (clkEn) begin
      if (restoreNow) begin
        rComp <= RST_COMP;
      end else if (wrComp) begin
        rComp <= regWrData;
      end
    end
  end

  // readback; unmapped offsets read as zero
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      regRdData <= RD_UNMAPPED;
    end else if (clkEn && regRdEn) begin
      if (regAddr == ADDR_VOLTAGE) begin
        regRdData <= rVoltage;
      end else if (regAddr == ADDR_TERM) begin
        regRdData <= rTerm;
      end else if (regAddr == ADDR_COMP) begin
        regRdData <= rComp;
      end else begin
        regRdData <= RD_UNMAPPED;
      end
    end
  end

  // a rewrite of the period register also counts as a restart
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tickCnt <= '0;
      secCnt  <= '0;
    end else if (clkEn) begin
      if (wdRestart || wrTerm || expireNow || regResetCmd ||
          rTerm[WD_MSB:WD_LSB] == WD_SEL_OFF) begin
        tickCnt <= '0;
        secCnt  <= '0;
      end else if (tickCnt == TICK_CYCLES - 1) begin
        tickCnt <= '0;
        secCnt  <= secCnt + 8'h01;
      end else begin
        tickCnt <= tickCnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wdRestartDone <= 1'b0;
      wdExpired     <= 1'b0;
    end else if (clkEn) begin
      wdRestartDone <= wdRestart;
      wdExpired     <= expireNow;
    end else begin
      wdRestartDone <= 1'b0;
      wdExpired     <= 1'b0;
    end
  end

  assign cfg.chargeVoltageCode     = rVoltage[CVC_MSB:CVC_LSB];
  assign cfg.prechargeThresholdSel = rVoltage[PRECHG_BIT];
  assign cfg.rechargeOffsetSel     = rVoltage[RECHG_BIT];
  assign cfg.terminationEnable     = rTerm[TERM_EN_BIT];
  assign cfg.statusPinDisable      = rTerm[STATUS_OFF_BIT];
  assign cfg.watchdogPeriodSel     = rTerm[WD_MSB:WD_LSB];
  assign cfg.safetyTimerEnable     = rTerm[TMR_EN_BIT];
  assign cfg.fastChargeDuration    = rTerm[FCD_MSB:FCD_LSB];
  assign cfg.reservedBit           = rTerm[RSVD_BIT];
  assign cfg.irCompResistance      = rComp[IRR_MSB:IRR_LSB];
  assign cfg.irCompVoltageClamp    = rComp[IRV_MSB:IRV_LSB];
  assign cfg.thermalLimitSel       = rComp[THERM_MSB:THERM_LSB];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  property p_cvc_store;
    wrOk && wrVoltage && regWrData[CVC_MSB:CVC_LSB] <= CVC_MAX_CODE
      |=> cfg.chargeVoltageCode == $past(regWrData[CVC_MSB:CVC_LSB]);
  endproperty
  a_cvc_store: assert property (p_cvc_store)
    else $error("voltage code not stored");

  property p_cvc_clamp;
    wrOk && wrVoltage && regWrData[CVC_MSB:CVC_LSB] > CVC_MAX_CODE
      |=> cfg.chargeVoltageCode == CVC_MAX_CODE;
  endproperty
  a_cvc_clamp: assert property (p_cvc_clamp)
    else $error("voltage code not clamped");

  property p_prechg;
    wrOk && wrVoltage
      |=> cfg.prechargeThresholdSel == $past(regWrData[PRECHG_BIT]);
  endproperty
  a_prechg: assert property (p_prechg)
    else $error("precharge select wrong");

  property p_rechg;
    wrOk && wrVoltage
      |=> cfg.rechargeOffsetSel == $past(regWrData[RECHG_BIT]);
  endproperty
  a_rechg: assert property (p_rechg)
    else $error("recharge select wrong");

  property p_term_fields;
    wrOk && wrTerm |=> {cfg.terminationEnable, cfg.statusPinDisable,
                        cfg.watchdogPeriodSel, cfg.safetyTimerEnable,
                        cfg.fastChargeDuration, cfg.reservedBit}
                       == $past(regWrData);
  endproperty
  a_term_fields: assert property (p_term_fields)
    else $error("termination fields wrong");

  // an off watchdog keeps its count at zero and never fires
  property p_wd_off;
    cfg.watchdogPeriodSel == WD_SEL_OFF |-> secCnt == 8'h00 && !wdExpired;
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("disabled watchdog counted or expired");

  property p_comp;
    wrOk && wrComp |=> {cfg.irCompResistance, cfg.irCompVoltageClamp,
                        cfg.thermalLimitSel} == $past(regWrData);
  endproperty
  a_comp: assert property (p_comp)
    else $error("compensation register wrong");

  property p_restart;
    clkEn && wdRestart |=> wdRestartDone && secCnt == 8'h00;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart not acknowledged");

  property p_restore;
    clkEn && restoreNow |=> rVoltage == RST_VOLTAGE && rTerm == RST_TERM &&
                            rComp == RST_COMP;
  endproperty
  a_restore: assert property (p_restore)
    else $error("defaults not restored");

  c_clamp:  cover property (wrOk && wrVoltage &&
                            regWrData[CVC_MSB:CVC_LSB] > CVC_MAX_CODE);
  c_expire: cover property (clkEn && expireNow);
  c_rstcmd: cover property (clkEn && regResetCmd);
  c_freeze: cover property (!clkEn && regWrEn);

endmodule : ccr_charger_config_regs

// ==== rtl/ccr_pkg.sv ====
// constants, field layout and config carrier for the charger config regs
// assumes a 40 MHz ref_clk and an 8-bit internal register port
package ccr_pkg;

  // register offsets
  localparam logic [7:0] ADDR_VOLTAGE = 8'h06;
  localparam logic [7:0] ADDR_TERM    = 8'h07;
  localparam logic [7:0] ADDR_COMP    = 8'h08;

  // reset values
  localparam logic [7:0] RST_VOLTAGE  = 8'h82;
  localparam logic [7:0] RST_TERM     = 8'h9d;
  localparam logic [7:0] RST_COMP     = 8'h03;
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;

  // charge voltage code: 3.840 V offset, 16 mV per step
  localparam int         CVC_OFFSET_MV = 3840;
  localparam int         CVC_STEP_MV   = 16;
  localparam int         CVC_LSB       = 2;
  localparam int         CVC_MSB       = 7;
  localparam logic [5:0] CVC_MAX_CODE  = 6'h30;  // 4.608 V

  // field positions
  localparam int PRECHG_BIT   = 1;
  localparam int RECHG_BIT    = 0;
  localparam int TERM_EN_BIT  = 7;
  localparam int STATUS_OFF_BIT = 6;
  localparam int WD_MSB       = 5;
  localparam int WD_LSB       = 4;
  localparam int TMR_EN_BIT   = 3;
  localparam int FCD_MSB      = 2;
  localparam int FCD_LSB      = 1;
  localparam int RSVD_BIT     = 0;
  localparam int IRR_MSB      = 7;
  localparam int IRR_LSB      = 5;
  localparam int IRV_MSB      = 4;
  localparam int IRV_LSB      = 2;
  localparam int THERM_MSB    = 1;
  localparam int THERM_LSB    = 0;

  // watchdog periods in seconds
  localparam logic [1:0] WD_SEL_OFF = 2'h0;
  localparam logic [1:0] WD_SEL_40  = 2'h1;
  localparam logic [1:0] WD_SEL_80  = 2'h2;
  localparam logic [7:0] WD_40_S    = 8'h28;
  localparam logic [7:0] WD_80_S    = 8'h50;
  localparam logic [7:0] WD_160_S   = 8'ha0;

  // one-second tick
  localparam int unsigned CLK_HZ    = 40_000_000;
  localparam int unsigned WD_TICK_S = 1;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ * WD_TICK_S;

  typedef struct packed {
    logic [5:0] chargeVoltageCode;
    logic       prechargeThresholdSel;
    logic       rechargeOffsetSel;
    logic       terminationEnable;
    logic       statusPinDisable;
    logic [1:0] watchdogPeriodSel;
    logic       safetyTimerEnable;
    logic [1:0] fastChargeDuration;
    logic       reservedBit;
    logic [2:0] irCompResistance;
    logic [2:0] irCompVoltageClamp;
    logic [1:0] thermalLimitSel;
  } ccr_cfg_s;

endpackage : ccr_pkg

// ==== dv/ccr_host_model.sv ====
// host model driving the charger config register port
// assumes one-cycle strobes launched 2 ns after a ref_clk rise
module ccr_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] regRdData,
  output logic            regWrEn,
  output logic            regRdEn,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  output logic            regResetCmd,
  output logic            wdRestart
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regResetCmd = 1'b0;
    wdRestart = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #2;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge ref_clk);
    #2;
    regWrEn = 1'b0;
    // released data never shows the last value
    regWrData = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #2;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge ref_clk);
    #2;
    regRdEn = 1'b0;
    d = regRdData;
  endtask : rd
  task automatic pulse(input bit rst);
    @(posedge ref_clk);
    #2;
    if (rst) begin
      regResetCmd = 1'b1;
    end else begin
      wdRestart = 1'b1;
    end
    @(posedge ref_clk);
    #2;
    regResetCmd = 1'b0;
    wdRestart = 1'b0;
  endtask : pulse
endmodule : ccr_host_model

// ==== dv/ccr_charger_config_regs_test.sv ====
// self-checking bench for the charger config registers
// assumes TICK_CYCLES of 4, so one watchdog second is 4 clocks
module ccr_charger_config_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  import ccr_pkg::*;
  logic       ref_clk = 1'b0;
  logic       srst = 1'b1;
  logic       clkEn = 1'b1;
  logic       regWrEn, regRdEn, regResetCmd, wdRestart;
  logic       wdRestartDone, wdExpired;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [7:0] e [3];
  ccr_cfg_s   cfg;
  int         mismatches = 0;
  int         n_compared = 0;
  always #12.5 ref_clk = ~ref_clk;
  ccr_charger_config_regs #(.TICK_CYCLES(4)) DUT (
    .ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regResetCmd(regResetCmd),
    .wdRestart(wdRestart), .wdRestartDone(wdRestartDone),
    .wdExpired(wdExpired), .cfg(cfg));
  ccr_host_model host (
    .ref_clk(ref_clk), .regRdData(regRdData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regResetCmd(regResetCmd), .wdRestart(wdRestart));
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [23:0] x,
                     input logic [23:0] g);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // readback of all three plus the field view
  task automatic chk_all();
    logic [7:0] d;
    for (int i = 0; i < 3; i++) begin
      host.rd(8'h06 + 8'(i), d);
      chk("regRdData", {16'h0000, e[i]}, {16'h0000, d});
    end
    chk("cfg", {e[0], e[1], e[2]}, cfg);
  endtask : chk_all
  task automatic t_defaults();
    logic [7:0] d;
    e = '{8'h82, 8'h9d, 8'h03};
    chk_all();
    host.rd(8'h09, d);
    chk("unmapped", 24'h00_0000, {16'h0000, d});
  endtask : t_defaults
  task automatic t_fields();
    logic [7:0] a [10] = '{8'h06, 8'h06, 8'h06, 8'h06, 8'h07, 8'h07, 8'h07,
                           8'h08, 8'h08, 8'h08};
    logic [7:0] w [10] = '{8'hff, 8'hc1, 8'hbd, 8'h01, 8'h00, 8'hff, 8'h6a,
                           8'hff, 8'h00, 8'ha4};
    logic [7:0] x [10] = '{8'hc3, 8'hc1, 8'hbd, 8'h01, 8'h00, 8'hff, 8'h6a,
                           8'hff, 8'h00, 8'ha4};
    for (int i = 0; i < 10; i++) begin
      host.wr(a[i], w[i]);
      e[a[i] - 8'h06] = x[i];
      chk_all();
    end
  endtask : t_fields
  task automatic t_restart();
    host.pulse(1'b0);
    chk("wdRestartDone", 24'h1, {23'h0, wdRestartDone});
    @(posedge ref_clk);
    #2;
    chk("wdRestartDone", 24'h0, {23'h0, wdRestartDone});
  endtask : t_restart
  // counts clocks from the period write until expiry, bounded
  task automatic t_expire(input logic [7:0] t, input int lo, input int hi);
    int n;
    n = 0;
    host.wr(8'h08, 8'ha4);
    host.wr(8'h07, t);
    while (wdExpired !== 1'b1 && n < hi) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("expiryInWindow", 24'h1, {23'h0, n >= lo && n < hi});
    if (n >= hi) summarize();
    e = '{8'h82, 8'h9d, 8'h03};
    chk_all();
  endtask : t_expire
  task automatic t_wd_off();
    host.wr(8'h07, 8'h8d);
    repeat (800) begin
      @(posedge ref_clk);
      #1;
      if (wdExpired !== 1'b0) begin
        chk("wdExpired", 24'h0, {23'h0, wdExpired});
        summarize();
      end
    end
    host.wr(8'h06, 8'h40);
    host.pulse(1'b1);
    e = '{8'h82, 8'h9d, 8'h03};
    chk_all();
  endtask : t_wd_off
  // a low clock enable or an unmapped offset leaves every field alone
  task automatic t_freeze();
    @(posedge ref_clk);
    #2;
    clkEn = 1'b0;
    host.wr(8'h06, 8'h00);
    clkEn = 1'b1;
    chk_all();
    host.wr(8'h05, 8'hff);
    host.wr(8'h09, 8'hff);
    chk_all();
  endtask : t_freeze
  // mid-run reset restores defaults and clears the read data
  task automatic t_srst();
    host.wr(8'h08, 8'ha4);
    srst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #2;
    chk("regRdData", 24'h00_0000, {16'h0000, regRdData});
    srst = 1'b0;
    e = '{8'h82, 8'h9d, 8'h03};
    chk_all();
  endtask : t_srst
  initial begin
    repeat (16) @(posedge ref_clk);
    #2;
    srst = 1'b0;
    t_defaults();
    t_fields();
    t_restart();
    t_expire(8'h9d, 150, 200);
    t_expire(8'had, 310, 400);
    t_wd_off();
    t_freeze();
    t_srst();
    summarize();
  end
endmodule : ccr_charger_config_regs_test
